/* rtl/rtc_pkg.sv */
// Constants and types shared by the serial client port of the clock/calendar
package rtc_pkg;
    localparam logic [3:0] CTRL_CODE = 4'hD;
    localparam logic [2:0] CHIP_SEL = 3'h7;
    localparam logic [6:0] CLIENT_ADDR = {CTRL_CODE, CHIP_SEL};
    localparam logic [7:0] RTCC_FIRST = 8'h00;
    localparam logic [7:0] RTCC_LAST = 8'h1F;
    localparam logic [7:0] SRAM_FIRST = 8'h20;
    localparam logic [7:0] SRAM_LAST = 8'h5F;
    localparam int MEM_DEPTH = 96;
    localparam int CLK_MHZ = 100;
    localparam int HOLD_NS = 300;
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int BUF_DEPTH = 2;
    localparam int CTRL_OUT_BIT = 7;
    localparam int CTRL_SQWEN_BIT = 6;
    localparam int CTRL_EXTOSC_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] CTRL_ADDR = 8'h07;
    typedef enum logic [2:0] {
        RTC_IDLE = 3'b000,
        RTC_RX = 3'b001,
        RTC_ACK = 3'b010,
        RTC_TX = 3'b011,
        RTC_TXACK = 3'b100,
        RTC_IGNORE = 3'b101
    } rtc_state_e;
endpackage

/* rtl/rtc_sync.sv */
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module rtc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } rtc_sync_s;
    rtc_sync_s r;
    rtc_sync_s next_r;
    always_comb
    begin
        next_r.meta = async_in;
        next_r.stable = r.meta;
    end
    always_ff @(posedge clk)
    begin
        if (reset)
            r <= '1;
        else
            r <= next_r;
    end
    assign sync_out = r.stable;
endmodule // rtc_sync
`default_nettype wire

/* rtl/rtc_buf.sv */
// Two-entry skid buffer between the serial port and the memory side
`timescale 1ns/1ns
`default_nettype none
module rtc_buf #(
    parameter int WIDTH = 9
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0] count;
        logic rd;
        logic wr;
    } rtc_buf_s;
    rtc_buf_s r;
    rtc_buf_s next_r;
    logic push;
    logic pop;
    always_comb
    begin
        next_r = r;
        push = in_valid && (r.count != 2'h2);
        pop = out_valid && out_ready;
        if (push)
        begin
            next_r.mem[r.wr] = in_data;
            next_r.wr = ~r.wr;
        end
        if (pop)
            next_r.rd = ~r.rd;
        next_r.count = 2'(r.count + {1'b0, push} - {1'b0, pop});
    end
    always_ff @(posedge clk)
    begin
        if (reset)
            r <= '0;
        else
            r <= next_r;
    end
    assign in_ready = r.count != 2'h2;
    assign out_valid = r.count != 2'h0;
    assign out_data = r.mem[r.rd];
endmodule // rtc_buf
`default_nettype wire

/* rtl/rtc_client.sv */
// Two-wire client port with register/SRAM store of the clock/calendar
`timescale 1ns/1ns
`default_nettype none
module rtc_client
    import rtc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic on_backup,
    input wire logic crystal_clock_input,
    input wire logic crystal_osc_clock,
    input wire logic alarm_level,
    input wire logic square_wave,
    output logic multifunction_output_pin_oe,
    output logic time_clock
);
    import rtc_pkg::*;

    typedef struct packed {
        rtc_state_e state;
        logic scl_d;
        logic sda_d;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic first_byte;
        logic addr_phase;
        logic [7:0] ptr;
        logic ack_low;
        logic drive_low;
        logic [7:0] hold_cnt;
        logic [7:0] ctrl;
        logic mfp_low;
        logic tclk;
        logic wr_valid;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } rtc_client_s;

    rtc_client_s r;
    rtc_client_s next_r;
    logic [7:0] mem [MEM_DEPTH];
    logic [1:0] pins_sync;
    logic [1:0] osc_sync;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [15:0] buf_out_data;
    logic [7:0] rd_byte;

    function automatic logic addr_ok(input logic [7:0] a);
        return (a <= RTCC_LAST) || ((a >= SRAM_FIRST) && (a <= SRAM_LAST));
    endfunction

    rtc_sync #(.WIDTH(2)) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_sync)
    );
    rtc_sync #(.WIDTH(2)) u_osc_sync (
        .clk(clk),
        .reset(reset),
        .async_in({crystal_clock_input, crystal_osc_clock}),
        .sync_out(osc_sync)
    );
    // Writes queue through a two-entry buffer so a store never drops a byte
    rtc_buf #(.WIDTH(16)) u_wr_buf (
        .clk(clk),
        .reset(reset),
        .in_valid(r.wr_valid),
        .in_ready(buf_in_ready),
        .in_data({r.wr_addr, r.wr_data}),
        .out_valid(buf_out_valid),
        .out_ready(1'b1),
        .out_data(buf_out_data)
    );

    assign scl = pins_sync[1];
    assign sda = pins_sync[0];
    assign scl_rise = scl && !r.scl_d;
    assign scl_fall = !scl && r.scl_d;
    assign start_seen = scl && r.scl_d && r.sda_d && !sda;
    assign stop_seen = scl && r.scl_d && !r.sda_d && sda;
    assign rd_byte = (r.ptr < 8'(MEM_DEPTH)) ? mem[r.ptr[6:0]] : 8'h00;

    always_comb
    begin
        next_r = r;
        next_r.scl_d = scl;
        next_r.sda_d = sda;
        next_r.wr_valid = 1'b0;
        // Hold count loads at the ack's SCL fall, but data moves on the fall itself, not after the hold
        if (r.hold_cnt != 8'h00)
            next_r.hold_cnt = 8'(r.hold_cnt - 8'h01);
        if (on_backup)
        begin
            next_r.state = RTC_IDLE;
            next_r.drive_low = 1'b0;
        end
        else if (start_seen)
        begin
            next_r.state = RTC_RX;
            next_r.bit_cnt = 3'h0;
            next_r.first_byte = 1'b1;
            // A pointer phase left over from a cut write must not carry into the next command
            next_r.addr_phase = 1'b0;
            next_r.drive_low = 1'b0;
        end
        else if (stop_seen)
        begin
            next_r.state = RTC_IDLE;
            next_r.drive_low = 1'b0;
        end
        else
        begin
            unique case (r.state)
                RTC_IDLE, RTC_IGNORE:
                    next_r.drive_low = 1'b0;
                RTC_RX:
                    if (scl_rise)
                    begin
                        next_r.shift = {r.shift[6:0], sda};
                        next_r.bit_cnt = 3'(r.bit_cnt + 3'h1);
                        if (r.bit_cnt == 3'h7)
                        begin
                            next_r.state = RTC_ACK;
                            next_r.ack_low = 1'b1;
                            if (r.first_byte)
                                next_r.ack_low = r.shift[6:0] == CLIENT_ADDR;
                            else if (r.addr_phase)
                                next_r.ack_low = addr_ok({r.shift[6:0], sda});
                        end
                    end
                RTC_ACK:
                    if (scl_fall && r.hold_cnt == 8'h00 && !r.drive_low)
                    begin
                        next_r.drive_low = r.ack_low;
                        next_r.hold_cnt = 8'(HOLD_CYC);
                        if (!r.ack_low)
                            next_r.state = RTC_IGNORE;
                    end
                    else if (scl_fall && r.drive_low)
                    begin
                        // Ack held low over the whole high phase; now act on the byte
                        next_r.bit_cnt = 3'h0;
                        next_r.drive_low = 1'b0;
                        next_r.state = RTC_RX;
                        if (r.first_byte)
                        begin
                            next_r.first_byte = 1'b0;
                            if (r.shift[0])
                            begin
                                next_r.state = RTC_TX;
                                next_r.drive_low = !rd_byte[7];
                            end
                            else
                                next_r.addr_phase = 1'b1;
                        end
                        else if (r.addr_phase)
                        begin
                            next_r.addr_phase = 1'b0;
                            next_r.ptr = r.shift;
                        end
                        else
                        begin
                            next_r.wr_valid = buf_in_ready;
                            next_r.wr_addr = r.ptr;
                            next_r.wr_data = r.shift;
                            next_r.ptr = addr_ok(8'(r.ptr + 8'h01)) ? 8'(r.ptr + 8'h01) : RTCC_FIRST;
                        end
                    end
                RTC_TX:
                    if (scl_fall)
                    begin
                        next_r.bit_cnt = 3'(r.bit_cnt + 3'h1);
                        if (r.bit_cnt == 3'h7)
                        begin
                            next_r.state = RTC_TXACK;
                            next_r.drive_low = 1'b0;
                        end
                        else
                            next_r.drive_low = !rd_byte[3'h6 - r.bit_cnt];
                    end
                RTC_TXACK:
                    if (scl_rise)
                    begin
                        next_r.ptr = addr_ok(8'(r.ptr + 8'h01)) ? 8'(r.ptr + 8'h01) : RTCC_FIRST;
                        next_r.state = sda ? RTC_IGNORE : RTC_TXACK;
                        next_r.bit_cnt = 3'h0;
                    end
                    else if (scl_fall && r.bit_cnt == 3'h0)
                    begin
                        next_r.state = RTC_TX;
                        next_r.drive_low = !rd_byte[7];
                    end
                default:
                    next_r.state = RTC_IDLE;
            endcase
        end
        // Keep the bit count in TXACK between clock edges while it is not zero
        if (r.state == RTC_TXACK && !scl_rise && !scl_fall && r.bit_cnt != 3'h0)
            next_r.bit_cnt = r.bit_cnt;
        // Multifunction pin: alarm, square wave, or the OUT general-purpose level
        if (r.ctrl[CTRL_SQWEN_BIT])
            next_r.mfp_low = !square_wave;
        else if (alarm_level)
            next_r.mfp_low = 1'b1;
        else
            next_r.mfp_low = !r.ctrl[CTRL_OUT_BIT];
        next_r.tclk = r.ctrl[CTRL_EXTOSC_BIT] ? osc_sync[1] : osc_sync[0];
        if (buf_out_valid && buf_out_data[15:8] == CTRL_ADDR)
            next_r.ctrl = buf_out_data[7:0];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r <= '0;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
            r.ctrl <= CTRL_RESET;
            r.state <= RTC_IDLE;
        end
        else
            r <= next_r;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            // Cleared so a read ahead of any write shifts out a defined byte
            for (int i = 0; i < MEM_DEPTH; i++)
                mem[i] <= 8'h00;
        end
        else if (buf_out_valid && buf_out_data[15:8] < 8'(MEM_DEPTH))
            mem[buf_out_data[14:8]] <= buf_out_data[7:0];
    end

    assign sda_out = 1'b0;
    assign sda_oe = r.drive_low;
    assign multifunction_output_pin_oe = r.mfp_low;
    assign time_clock = r.tclk;

    a_backup_quiet: assert property (@(posedge clk) disable iff (reset)
        $past(on_backup) |-> !sda_oe) else $error("Port drives bus on backup");
    a_start_aborts: assert property (@(posedge clk) disable iff (reset)
        start_seen && !on_backup |=> r.state == RTC_RX && r.bit_cnt == 3'h0) else $error("Start not honoured");
    a_stop_idles: assert property (@(posedge clk) disable iff (reset)
        stop_seen && !start_seen |=> r.state == RTC_IDLE && !sda_oe) else $error("Stop not honoured");
    a_no_drive_high: assert property (@(posedge clk) disable iff (reset)
        scl && r.scl_d && $rose(sda_oe) |-> $past(r.state) == RTC_TXACK || $past(r.state) == RTC_ACK)
        else $error("SDA moved while SCL high");
    a_ignore_quiet: assert property (@(posedge clk) disable iff (reset)
        r.state == RTC_IGNORE |-> !sda_oe) else $error("Drive while ignoring");
    a_nack_release: assert property (@(posedge clk) disable iff (reset)
        r.state == RTC_TXACK && scl_rise && sda && !start_seen && !stop_seen && !on_backup
        |=> r.state == RTC_IGNORE ##1 !sda_oe) else $error("No release after nack");
    a_bad_addr_nack: assert property (@(posedge clk) disable iff (reset)
        r.state == RTC_ACK && !r.ack_low |-> !sda_oe) else $error("Acked a bad address");
    a_mfp_out: assert property (@(posedge clk) disable iff (reset)
        !r.ctrl[CTRL_SQWEN_BIT] && !alarm_level |=> multifunction_output_pin_oe == !$past(r.ctrl[CTRL_OUT_BIT]))
        else $error("Pin not following OUT");
    a_ack_stands: assert property (@(posedge clk) disable iff (reset)
        r.state == RTC_ACK && r.drive_low && !scl_fall && !start_seen && !stop_seen && !on_backup
        |=> sda_oe) else $error("Ack dropped before clock fall");
    c_start: cover property (@(posedge clk) start_seen);
    c_nack: cover property (@(posedge clk) r.state == RTC_IGNORE);
    c_ack: cover property (@(posedge clk) r.state == RTC_ACK && sda_oe);
    c_read: cover property (@(posedge clk) r.state == RTC_TX);
    c_write: cover property (@(posedge clk) r.wr_valid);
endmodule // rtc_client
`default_nettype wire

/* tb/rtc_host.sv */
// Behavioural bus host that clocks the two-wire client port
`timescale 1ns/1ns
`default_nettype none
module rtc_host #(
    parameter real TQ = 60.0
) (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Low phase stretched to eight quarters so the port's 300 ns data hold fits in it
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start();
        sda_low = 1'b0;
        #(2 * TQ);
        scl = 1'b1;
        #(2 * TQ);
        sda_low = 1'b1;
        #(2 * TQ);
        scl = 1'b0;
    endtask
    task automatic clock_bit(input logic val, output logic got);
        #(2 * TQ);
        sda_low = !val;
        #(6 * TQ);
        scl = 1'b1;
        #(TQ);
        got = sda;
        #(TQ);
        scl = 1'b0;
    endtask
    task automatic send(input logic [7:0] data, input int n, output logic ack);
        logic got;
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--)
            clock_bit(data[i], got);
        if (n == 8)
        begin
            clock_bit(1'b1, got);
            ack = !got;
        end
    endtask
    task automatic recv(input logic ack, output logic [7:0] data);
        logic got;
        for (int i = 7; i >= 0; i--)
            clock_bit(1'b1, data[i]);
        clock_bit(!ack, got);
    endtask
    task automatic stop();
        #(2 * TQ);
        sda_low = 1'b1;
        #(6 * TQ);
        scl = 1'b1;
        #(2 * TQ);
        sda_low = 1'b0;
        #(4 * TQ);
    endtask
endmodule // rtc_host
`default_nettype wire

/* tb/test_rtcc_i2c_client_port.sv */
// Self-checking bench for the two-wire client port
`timescale 1ns/1ns
`default_nettype none
module test_rtcc_i2c_client_port;
    import rtc_pkg::*;
    typedef struct {logic [7:0] ctrl; logic ack;} rtc_row_s;
    logic clk, reset, scl, host_low, on_backup, ext_clk, osc_clk;
    logic sda_out, sda_oe, mfp_oe, time_clock, ack;
    logic alarm_level, square_wave;
    logic [7:0] rd;
    wire sda;
    int error_cnt = 0;
    int n_checks = 0;
    rtc_row_s rows [5] = '{'{8'hDE, 1'b1}, '{8'hDF, 1'b1}, '{8'hAE, 1'b0}, '{8'hD6, 1'b0}, '{8'h5E, 1'b0}};
    // Open-drain wire with pull-up: low when either party pulls
    assign sda = !(host_low || (sda_oe && !sda_out));
    rtc_host u_rtc_host (.scl(scl), .sda_low(host_low), .sda(sda));
    rtc_client u_rtc_client (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .on_backup(on_backup), .crystal_clock_input(ext_clk), .crystal_osc_clock(osc_clk),
        .alarm_level(alarm_level), .square_wave(square_wave), .multifunction_output_pin_oe(mfp_oe),
        .time_clock(time_clock));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s %h", $time, msg, got);
        end
    endtask
    task automatic put(input logic [7:0] b, input logic exp);
        u_rtc_host.send(b, 8, ack);
        check_bit(ack, exp, "ack slot");
    endtask
    task automatic clk_sel(input logic ext);
        for (int v = 0; v < 2; v++)
        begin
            @(negedge clk);
            ext_clk = v[0];
            osc_clk = !v[0];
            repeat (10) @(negedge clk);
            check_bit(time_clock, ext ? v[0] : !v[0], "time clock source");
        end
    endtask
    initial
    begin
        #900000;
        error_cnt++;
        $display("wrong value at %0t: watchdog ran out", $time);
        close_out();
    end
    initial
    begin
        reset = 1'b1;
        on_backup = 1'b0;
        alarm_level = 1'b0;
        square_wave = 1'b0;
        ext_clk = 1'b0;
        osc_clk = 1'b0;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        check_bit(sda_oe, 1'b0, "data line after reset");
        check_bit(sda_out, 1'b0, "data drive level");
        check_bit(mfp_oe, 1'b0, "pin after reset");
        repeat (3) @(negedge clk);
        foreach (rows[i])
        begin
            u_rtc_host.start();
            put(rows[i].ctrl, rows[i].ack);
            if (ack && rows[i].ctrl[0])
                u_rtc_host.recv(1'b0, rd);
            u_rtc_host.stop();
            $display("row %0d done", i);
        end
        // General-purpose level and external clock select
        clk_sel(1'b0);
        u_rtc_host.start();
        put(8'hDE, 1'b1);
        put(CTRL_ADDR, 1'b1);
        put(8'h08, 1'b1);
        u_rtc_host.stop();
        repeat (10) @(negedge clk);
        check_bit(mfp_oe, 1'b1, "pin follows level bit");
        clk_sel(1'b1);
        $display("control test done");
        // Second reset restores the control byte
        reset = 1'b1;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        check_bit(mfp_oe, 1'b0, "pin after second reset");
        clk_sel(1'b0);
        // Alarm pulls the pin although the level bit is high
        alarm_level = 1'b1;
        repeat (4) @(negedge clk);
        check_bit(mfp_oe, 1'b1, "pin carries alarm");
        alarm_level = 1'b0;
        // Square wave steers the pin once its enable is set
        u_rtc_host.start();
        put(8'hDE, 1'b1);
        put(CTRL_ADDR, 1'b1);
        put(8'h40, 1'b1);
        u_rtc_host.stop();
        for (int v = 0; v < 2; v++)
        begin
            @(negedge clk);
            square_wave = v[0];
            repeat (4) @(negedge clk);
            check_bit(mfp_oe, !v[0], "pin carries square wave");
        end
        square_wave = 1'b0;
        $display("reset test done");
        // Burst across the top of user memory wraps to zero
        u_rtc_host.start();
        put(8'hDE, 1'b1);
        put(SRAM_LAST, 1'b1);
        put(8'hA5, 1'b1);
        put(8'h3C, 1'b1);
        u_rtc_host.stop();
        u_rtc_host.start();
        put(8'hDE, 1'b1);
        put(SRAM_LAST, 1'b1);
        u_rtc_host.start();
        put(8'hDF, 1'b1);
        u_rtc_host.recv(1'b1, rd);
        check_byte(rd, 8'hA5, "read top of memory");
        u_rtc_host.recv(1'b0, rd);
        check_byte(rd, 8'h3C, "read wrapped byte");
        repeat (40) @(negedge clk);
        check_bit(sda_oe, 1'b0, "data line after nack");
        u_rtc_host.stop();
        $display("memory test done");
        // Pointer outside the address space
        u_rtc_host.start();
        put(8'hDE, 1'b1);
        put(SRAM_LAST + 8'h01, 1'b0);
        u_rtc_host.stop();
        // Start in mid-byte aborts and a fresh control byte is taken
        u_rtc_host.start();
        put(8'hDE, 1'b1);
        u_rtc_host.send(8'h07, 4, ack);
        u_rtc_host.start();
        put(8'hDE, 1'b1);
        u_rtc_host.stop();
        $display("range and abort tests done");
        // Backup supply silences the port
        on_backup = 1'b1;
        u_rtc_host.start();
        put(8'hDE, 1'b0);
        u_rtc_host.stop();
        on_backup = 1'b0;
        $display("backup test done");
        close_out();
    end
endmodule // test_rtcc_i2c_client_port
`default_nettype wire
